// ### remap_input_defs.svh
// Constants of the remappable input selector: offsets, fields, resets, codes.
// Assumes inclusion by bare name from the package and the selector module.
`ifndef REMAP_INPUT_DEFS_SVH
`define REMAP_INPUT_DEFS_SVH

// Register byte offsets on the APB
`define OFS_EXT_IRQ2_INPUT_SELECT        12'h000
`define OFS_TIMER2_CLOCK_INPUT_SELECT    12'h004
`define OFS_CAPTURE1_2_INPUT_SELECT      12'h008
`define OFS_CAPTURE3_4_INPUT_SELECT      12'h00C
`define OFS_COMPARE_FAULT_A_INPUT_SELECT 12'h010
`define OFS_PWM_FAULT_INPUT_SELECT       12'h014
`define OFS_ENCODER_PHASE_INPUT_SELECT   12'h018
`define OFS_ENCODER_HOME_INDEX_SELECT    12'h01C

// Number of selector registers and field slots (two per register)
`define NUM_SEL_REGS                     8
`define NUM_SEL_SLOTS                    16

// Field positions inside a register
`define LOW_FIELD_LSB                    0
`define LOW_FIELD_MSB                    6
`define HIGH_FIELD_LSB                   8
`define HIGH_FIELD_MSB                   14

// Field width and reset value
`define SEL_WIDTH                        7
`define SEL_RESET                        7'h00

// Special selector codes
`define CODE_TIED_LOW                    7'h00
`define CODE_COMPARATOR_ONE              7'h01
`define CODE_LAST_PIN                    7'h79

// Slots holding a real field (bit 2r low field, 2r+1 high field of reg r)
`define SLOT_IMPL_MASK                   16'hFDF5

// Selector codes that name an implemented remappable pin
`define PIN_IMPL_MASK  128'h03C00003_C0000000_06001FFF_1B100000

`endif

// ### remap_input_pkg.sv
// Types shared by the remappable input selector.
// Assumes remap_input_defs.svh is on the include path.
`include "remap_input_defs.svh"

package remap_input_pkg;

  // One selector field
  typedef logic [`SEL_WIDTH-1:0] sel_code_type;

  // APB data word
  typedef logic [31:0]           apb_data_type;

  // APB address
  typedef logic [11:0]           apb_addr_type;

  // Raw remappable pin levels, indexed by selector code
  typedef logic [127:0]          pin_vector_type;

endpackage

// ### remappable_input_select.sv
// Remappable input selector: APB register file and source multiplexers.
// Assumes pin and comparator inputs are already synchronous to i_clk.
//
// Overview of operation
// - Code zero ties the peripheral input low.
// - Code one routes comparator one output.
// - Code 121 selects the last remappable pin.
// - Single-field registers read zero in bits 15-7.
// - Fields are read/write and reset to zero.
// - External interrupt two selector in bits 6-0.
// - Timer two clock selector in bits 6-0.
// - Capture two high field, capture one low.
// - Capture four high field, capture three low.
// - Compare fault A selector in bits 6-0.
// - PWM fault two high, fault one low.
// - Encoder phase B high, phase A low.
// - Encoder home high, index low.
// - Dual-field registers read zero in 15, 7.
// - Other codes select the pin of that number; codes naming no pin tie it low.
// - No lockout; one source may feed many.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "remap_input_defs.svh"

module remappable_input_select (
  input  wire logic                          i_clk,                 // System clock, 200 MHz
  input  wire logic                          i_rst_n,               // Async reset, active low
  input  wire logic                          i_clk_en,              // Freezes all state when low
  // APB slave
  input  wire logic                          i_psel,                // Slave select
  input  wire logic                          i_penable,             // Access phase
  input  wire logic                          i_pwrite,              // Write direction
  input  wire remap_input_pkg::apb_addr_type i_paddr,               // Byte address
  input  wire remap_input_pkg::apb_data_type i_pwdata,              // Write data
  input  wire logic [3:0]                    i_pstrb,               // Byte strobes
  output logic                               o_pready,              // Transfer done
  output remap_input_pkg::apb_data_type      o_prdata,              // Read data
  output logic                               o_pslverr,             // Unmapped address
  // Sources
  input  wire remap_input_pkg::pin_vector_type i_remappable_pin,    // Pin levels by code
  input  wire logic                          i_comparator_one_out,  // Comparator one output
  // Peripheral inputs
  output logic                               o_ext_irq2_input,      // External interrupt two
  output logic                               o_timer2_ext_clock,    // Timer two ext clock
  output logic                               o_capture1_input,      // Input capture one
  output logic                               o_capture2_input,      // Input capture two
  output logic                               o_capture3_input,      // Input capture three
  output logic                               o_capture4_input,      // Input capture four
  output logic                               o_compare_fault_a,     // Compare fault A
  output logic                               o_pwm_fault_one,       // PWM fault one
  output logic                               o_pwm_fault_two,       // PWM fault two
  output logic                               o_encoder_phase_a,     // Encoder phase A
  output logic                               o_encoder_phase_b,     // Encoder phase B
  output logic                               o_encoder_home_in,     // Encoder home
  output logic                               o_encoder_index_in     // Encoder index
);
  import remap_input_pkg::*;

  // Selector fields, slot 2r low field and 2r+1 high field of register r
  sel_code_type                sel_reg [`NUM_SEL_SLOTS];
  // Routed level of each slot, combinational
  logic [`NUM_SEL_SLOTS-1:0]   routed_next;
  // Which slots exist
  localparam logic [`NUM_SEL_SLOTS-1:0] SLOT_IMPL = `SLOT_IMPL_MASK;
  // Which codes name a real pin
  localparam pin_vector_type   PIN_IMPL  = `PIN_IMPL_MASK;

  // APB decode
  logic                        access_phase;   // Psel and penable both high
  logic                        write_commit;   // Edge at which a write lands
  logic                        addr_hit;       // Address names a register
  logic [2:0]                  reg_index;      // Register number from address
  apb_data_type                read_word;      // Assembled read value

  assign access_phase = i_psel && i_penable;
  assign write_commit = access_phase && o_pready && i_pwrite;

  // Address decode to register number
  always_comb
  begin
    addr_hit  = 1'b1;
    reg_index = 3'h0;
    case (i_paddr)
      `OFS_EXT_IRQ2_INPUT_SELECT:        reg_index = 3'h0;
      `OFS_TIMER2_CLOCK_INPUT_SELECT:    reg_index = 3'h1;
      `OFS_CAPTURE1_2_INPUT_SELECT:      reg_index = 3'h2;
      `OFS_CAPTURE3_4_INPUT_SELECT:      reg_index = 3'h3;
      `OFS_COMPARE_FAULT_A_INPUT_SELECT: reg_index = 3'h4;
      `OFS_PWM_FAULT_INPUT_SELECT:       reg_index = 3'h5;
      `OFS_ENCODER_PHASE_INPUT_SELECT:   reg_index = 3'h6;
      `OFS_ENCODER_HOME_INDEX_SELECT:    reg_index = 3'h7;
      // Unmapped: error answer, reads zero
      default:                           addr_hit  = 1'b0;
    endcase
  end

  // Read word: unused and reserved bits are zero
  always_comb
  begin
    read_word = 32'h0000_0000;
    if (addr_hit)
    begin
      // Bits 15 and 7 and above 15 stay zero
      read_word[`LOW_FIELD_MSB:`LOW_FIELD_LSB]   = sel_reg[{reg_index, 1'b0}];
      // Single-field registers give zero here from a constant slot
      read_word[`HIGH_FIELD_MSB:`HIGH_FIELD_LSB] = sel_reg[{reg_index, 1'b1}];
    end
  end

  // Per-slot field storage and source multiplexer
  genvar s;
  generate
    for (s = 0; s < `NUM_SEL_SLOTS; s = s + 1)
    begin : g_slot
      localparam logic [2:0] REG_NUM = 3'(s / 2);
      localparam bit         IS_HIGH = (s % 2) == 1;
      if (SLOT_IMPL[s])
      begin : g_impl
        logic hit_this;  // Write to this field's register and byte
        assign hit_this = write_commit && addr_hit && (reg_index == REG_NUM)
                          && (IS_HIGH ? i_pstrb[1] : i_pstrb[0]);
        // Field storage, read/write, reset to zero
        always_ff @(posedge i_clk or negedge i_rst_n)
        begin
          if (!i_rst_n)
            sel_reg[s] <= `SEL_RESET;
          else if (i_clk_en && hit_this)
          begin
            if (IS_HIGH)
              sel_reg[s] <= i_pwdata[`HIGH_FIELD_MSB:`HIGH_FIELD_LSB];
            else
              sel_reg[s] <= i_pwdata[`LOW_FIELD_MSB:`LOW_FIELD_LSB];
          end
        end
      end
      else
      begin : g_absent
        // No field here: constant zero, writes ignored
        assign sel_reg[s] = `SEL_RESET;
      end

      // Source selection for this slot; each slot decodes alone
      always_comb
      begin
        if (sel_reg[s] == `CODE_TIED_LOW)
          routed_next[s] = 1'b0;
        else if (sel_reg[s] == `CODE_COMPARATOR_ONE)
          routed_next[s] = i_comparator_one_out;
        else if (PIN_IMPL[sel_reg[s]])
          // Pin by number, up to the last code; shared sources allowed
          routed_next[s] = i_remappable_pin[sel_reg[s]];
        else
          // Code naming no pin
          routed_next[s] = 1'b0;
      end
    end
  endgenerate

  // APB handshake: one wait state, then ready for one cycle
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_pready <= 1'b0;
    else if (i_clk_en)
      o_pready <= access_phase && !o_pready;
  end

  // Read data and error, captured in the wait state
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (access_phase && !o_pready)
      begin
        // Reads return the word; writes return zero
        o_prdata  <= i_pwrite ? 32'h0000_0000 : read_word;
        o_pslverr <= !addr_hit;
      end
      else
      begin
        // Idle bus shows no data and no error
        o_prdata  <= 32'h0000_0000;
        o_pslverr <= 1'b0;
      end
    end
  end

  // External interrupt two from slot 0
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Tied low from reset
      o_ext_irq2_input <= 1'b0;
    end
    else if (i_clk_en)
    begin
      // Selected source, one clock late
      o_ext_irq2_input <= routed_next[0];
    end
  end

  // Timer two clock from slot 2
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Tied low from reset
      o_timer2_ext_clock <= 1'b0;
    end
    else if (i_clk_en)
    begin
      // Selected source, one clock late
      o_timer2_ext_clock <= routed_next[2];
    end
  end

  // Capture one from slot 4
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Tied low from reset
      o_capture1_input <= 1'b0;
    end
    else if (i_clk_en)
    begin
      // Selected source, one clock late
      o_capture1_input <= routed_next[4];
    end
  end

  // Capture two from slot 5
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Tied low from reset
      o_capture2_input <= 1'b0;
    end
    else if (i_clk_en)
    begin
      // Selected source, one clock late
      o_capture2_input <= routed_next[5];
    end
  end

  // Capture three from slot 6
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Tied low from reset
      o_capture3_input <= 1'b0;
    end
    else if (i_clk_en)
    begin
      // Selected source, one clock late
      o_capture3_input <= routed_next[6];
    end
  end

  // Capture four from slot 7
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Tied low from reset
      o_capture4_input <= 1'b0;
    end
    else if (i_clk_en)
    begin
      // Selected source, one clock late
      o_capture4_input <= routed_next[7];
    end
  end

  // Compare fault A from slot 8
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Tied low from reset
      o_compare_fault_a <= 1'b0;
    end
    else if (i_clk_en)
    begin
      // Selected source, one clock late
      o_compare_fault_a <= routed_next[8];
    end
  end

  // PWM fault one from slot 10
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Tied low from reset
      o_pwm_fault_one <= 1'b0;
    end
    else if (i_clk_en)
    begin
      // Selected source, one clock late
      o_pwm_fault_one <= routed_next[10];
    end
  end

  // PWM fault two from slot 11
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Tied low from reset
      o_pwm_fault_two <= 1'b0;
    end
    else if (i_clk_en)
    begin
      // Selected source, one clock late
      o_pwm_fault_two <= routed_next[11];
    end
  end

  // Encoder phase A from slot 12
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Tied low from reset
      o_encoder_phase_a <= 1'b0;
    end
    else if (i_clk_en)
    begin
      // Selected source, one clock late
      o_encoder_phase_a <= routed_next[12];
    end
  end

  // Encoder phase B from slot 13
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Tied low from reset
      o_encoder_phase_b <= 1'b0;
    end
    else if (i_clk_en)
    begin
      // Selected source, one clock late
      o_encoder_phase_b <= routed_next[13];
    end
  end

  // Encoder index from slot 14
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Tied low from reset
      o_encoder_index_in <= 1'b0;
    end
    else if (i_clk_en)
    begin
      // Selected source, one clock late
      o_encoder_index_in <= routed_next[14];
    end
  end

  // Encoder home from slot 15
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Tied low from reset
      o_encoder_home_in <= 1'b0;
    end
    else if (i_clk_en)
    begin
      // Selected source, one clock late
      o_encoder_home_in <= routed_next[15];
    end
  end

endmodule // remappable_input_select

// ### pin_source_model.sv
// Model of the pin and comparator levels that feed the selector.
// Levels change only by non-blocking assignment after a clock edge.
`timescale 1ns/1ps
module pin_source_model (
  output logic [127:0] o_pin, // Pin levels by code
  output logic         o_cmp  // Comparator one level
);
  // Quiet levels until the bench asks for others
  initial
  begin
    o_pin = '0;
    o_cmp = 1'b0;
  end
  // Apply new levels
  task automatic drive(input logic [127:0] p, input logic c);
    o_pin <= p;
    o_cmp <= c;
  endtask
endmodule // pin_source_model

// ### remap_select_props.sv
// Port checker for the remappable input selector.
// Bound to the top module from the bench file.
`timescale 1ns/1ps
`include "remap_input_defs.svh"
module remap_select_props (
  input wire logic                            i_clk,
  input wire logic                            i_rst_n,
  input wire logic                            i_psel,
  input wire logic                            i_penable,
  input wire logic                            i_pwrite,
  input wire remap_input_pkg::apb_addr_type   i_paddr,
  input wire remap_input_pkg::apb_data_type   i_pwdata,
  input wire logic [3:0]                      i_pstrb,
  input wire logic                            o_pready,
  input wire remap_input_pkg::apb_data_type   o_prdata,
  input wire logic                            o_pslverr,
  input wire remap_input_pkg::pin_vector_type i_remappable_pin,
  input wire logic                            i_comparator_one_out,
  input wire logic                            o_ext_irq2_input
);
  import remap_input_pkg::*;
  localparam logic [127:0] PIN_OK = `PIN_IMPL_MASK; // Codes naming a real pin
  sel_code_type irq2_sel_reg;                       // Shadow of interrupt two field
  // Follow completed writes to the interrupt two field
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      irq2_sel_reg <= `SEL_RESET;
    else if (i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0]
             && i_paddr == `OFS_EXT_IRQ2_INPUT_SELECT)
      irq2_sel_reg <= i_pwdata[6:0];
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_ready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("ready held past one cycle");
  a_error_no_data: assert property (o_pslverr |-> o_pready && o_prdata == '0)
    else $error("error without ready or with data");
  a_dual_gaps_zero: assert property (o_pready |-> o_prdata[31:15] == '0 && !o_prdata[7])
    else $error("unimplemented bits read nonzero");
  a_single_top_zero: assert property (o_pready && i_paddr == 12'h000 |-> o_prdata[15:7] == '0)
    else $error("single field register upper bits nonzero");
  a_reset_quiet: assert property ($rose(i_rst_n) |-> !o_ext_irq2_input && !o_pready)
    else $error("output active right after reset");
  a_code_zero_low: assert property (irq2_sel_reg == 7'h00 |=> !o_ext_irq2_input)
    else $error("tied low input is high");
  a_comparator_route: assert property (irq2_sel_reg == 7'h01 |=> o_ext_irq2_input == $past(i_comparator_one_out))
    else $error("comparator not routed");
  a_pin_route: assert property (PIN_OK[irq2_sel_reg] |=> o_ext_irq2_input == $past(i_remappable_pin[irq2_sel_reg]))
    else $error("pin not routed");
  a_no_pin_low: assert property (irq2_sel_reg > 7'h01 && !PIN_OK[irq2_sel_reg] |=> !o_ext_irq2_input)
    else $error("code without pin is high");
  c_unmapped: cover property (o_pready && o_pslverr);
  c_comparator: cover property (irq2_sel_reg == 7'h01 && o_ext_irq2_input);
  c_last_pin: cover property (irq2_sel_reg == 7'h79 && o_ext_irq2_input);
endmodule // remap_select_props

// ### tb_remappable_input_select.sv
// Bench for the remappable input selector: registers, routing, reset.
// Uses the pin model; binds the port checker at the foot.
`timescale 1ns/1ps
`include "remap_input_defs.svh"
module tb_remappable_input_select;
  import remap_input_pkg::*;
  logic           clk, rst_n, psel, penable, pwrite, cmp, pready, slverr;
  logic [3:0]     pstrb;
  apb_addr_type   paddr;
  apb_data_type   pwdata, prdata, rd;
  pin_vector_type pins;
  logic [12:0]    outs; // Peripheral inputs, interrupt two at the top
  int             err_count, check_count, cyc;
  apb_data_type   exp_rd [9] = '{32'h7F, 32'h7F, 32'h7F7F, 32'h7F7F, 32'h7F, 32'h7F7F,
                                 32'h7F7F, 32'h7F7F, 32'h0};
  remappable_input_select uut (.i_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(slverr), .i_remappable_pin(pins), .i_comparator_one_out(cmp),
    .o_ext_irq2_input(outs[12]), .o_timer2_ext_clock(outs[11]), .o_capture1_input(outs[10]),
    .o_capture2_input(outs[9]), .o_capture3_input(outs[8]), .o_capture4_input(outs[7]),
    .o_compare_fault_a(outs[6]), .o_pwm_fault_one(outs[5]), .o_pwm_fault_two(outs[4]),
    .o_encoder_phase_a(outs[3]), .o_encoder_phase_b(outs[2]),
    .o_encoder_index_in(outs[1]), .o_encoder_home_in(outs[0]));
  pin_source_model pm (.o_pin(pins), .o_cmp(cmp));
  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input apb_data_type seen, input apb_data_type exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer, held until ready is seen
  task automatic apb(input logic wr, input apb_addr_type a, input apb_data_type d,
                     input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Same codes in every register, then compare all peripheral inputs
  task automatic route(input sel_code_type lo, input sel_code_type hi,
                       input pin_vector_type p, input logic c, input logic [12:0] e);
    pm.drive(p, c);
    for (int i = 0; i < 8; i++)
      apb(1'b1, apb_addr_type'(i * 4), {17'h0, hi, 1'b0, lo}, 4'hF);
    repeat (3) @(posedge clk);
    chk({19'h0, outs}, {19'h0, e});
  endtask
  task automatic finish_test();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset value, all ones written, read back; last row is unmapped
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b0, apb_addr_type'(i * 4), '0, 4'hF);
      chk(rd, '0);
      apb(1'b1, apb_addr_type'(i * 4), '1, 4'hF);
      apb(1'b0, apb_addr_type'(i * 4), '0, 4'hF);
      chk(rd, exp_rd[i]);
    end
    apb(1'b1, `OFS_CAPTURE1_2_INPUT_SELECT, 32'h0505, 4'h1);
    apb(1'b0, `OFS_CAPTURE1_2_INPUT_SELECT, '0, 4'hF);
    chk(rd, 32'h7F05);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, `OFS_CAPTURE1_2_INPUT_SELECT, '0, 4'hF);
    chk(rd, '0);
    chk({19'h0, outs}, '0);
    route(7'h01, 7'h00, '0, 1'b1, 13'h1D6A);
    route(7'h00, 7'h01, '0, 1'b1, 13'h0295);
    route(7'h79, 7'h18, 128'h1 << 121, 1'b0, 13'h1D6A);
    route(7'h18, 7'h79, 128'h1 << 121, 1'b0, 13'h0295);
    route(7'h7F, 7'h02, '1, 1'b1, 13'h0000);
    finish_test();
  end
endmodule // tb_remappable_input_select
bind remappable_input_select remap_select_props chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_pready(o_pready), .o_prdata(o_prdata),
  .o_pslverr(o_pslverr), .i_remappable_pin(i_remappable_pin),
  .i_comparator_one_out(i_comparator_one_out), .o_ext_irq2_input(o_ext_irq2_input));
